// File: hw/pbc_basic_control.sv
// Operation
// - Writing bit 15 resets the transceiver and all registers; bit self-clears.
// - Bit 14 loops MAC transmit nibble to receive output, medium isolated.
// - Loopback passes through internal registered stages, exercising digital logic.
// - Bit 13 selects 100 Mb/s when one, 10 Mb/s when zero; resets one.
// - With autoneg on, speed and duplex bits ignore writes and do nothing.
// - Bit 12 enables auto-negotiation; resets to one.
// - With autoneg off, speed follows bit 13 and duplex bit 8.
// - Bit 11 requests low-power state.
// - Management reads and writes still answered while powered down.
// - Autoneg starts at power-up; bit 9 restarts it and self-clears.
// - Bit 8 selects full duplex when one, half when zero; resets one.
// - With bit 7 set, COL follows TX_EN from the MAC.
// - Coding sublayer bypass high suppresses the collision test.
// - Collision test works regardless of duplex mode.
// - Status bits 15..11 show fixed abilities, unaffected by control writes.
// - Only physical address 00001b is answered.
`timescale 1ns/1ps
`default_nettype none
module pbc_basic_control
    import pbc_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    // Management access
    input  wire pbc_mgmt_req_s mgmt_req,
    output var  logic [15:0]   mgmt_rdata,
    output var  logic          mgmt_rvalid,
    // MII towards MAC
    input  wire pbc_mii_tx_s   mac_tx,
    output var  pbc_mii_rx_s   mac_rx,
    // Medium side
    input  wire pbc_mii_rx_s   line_rx,
    output var  pbc_mii_tx_s   line_tx,
    // Vendor control and status
    input  wire logic          coding_sublayer_bypass,
    input  wire logic          link_status,
    input  wire logic          autoneg_complete,
    // Core controls
    output var  logic          core_reset,
    output var  logic          speed_100,
    output var  logic          full_duplex,
    output var  logic          autoneg_enable,
    output var  logic          autoneg_restart,
    output var  logic          low_power_request,
    output var  logic          digital_loopback_en
);
    // ***********************************************
    // Address decode
    // ***********************************************
    function automatic logic hit(input pbc_mgmt_req_s r, input logic [4:0] ra);
        hit = (r.phy_addr == PHY_MGMT_ADDRESS) && (r.reg_addr == ra);
    endfunction

    // Old enable bit decides, so one write cannot unlock and force together
    function automatic logic [15:0] write_mask(input logic aneg_on);
        write_mask = CTRL_WRITE_MASK;
        if (aneg_on) begin
            write_mask[BIT_SPEED]  = 1'b0;
            write_mask[BIT_DUPLEX] = 1'b0;
        end
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old_val,
                                          input logic [15:0] new_val,
                                          input logic [15:0] mask);
        merge = (old_val & ~mask) | (new_val & mask);
    endfunction

    // ***********************************************
    // Control register
    // ***********************************************
    logic [15:0] ctrl_q;
    logic [15:0] ctrl_d;
    logic [15:0] wmask;
    logic        ctrl_wr;

    always_comb begin
        // Power-down does not gate this path
        ctrl_wr = mgmt_req.wr && hit(mgmt_req, REG_BASIC_CONTROL);
        wmask   = write_mask(ctrl_q[BIT_ANEG_EN]);
        ctrl_d  = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = merge(ctrl_q, mgmt_req.wdata, wmask);
            if (mgmt_req.wdata[BIT_RESET]) begin
                // Other written bits are dropped on a soft reset
                ctrl_d = CTRL_RESET_VAL;
            end
        end
        ctrl_d[BIT_RESET]   = 1'b0;
        ctrl_d[BIT_RESTART] = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET_VAL;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ***********************************************
    // Self-clearing pulses
    // ***********************************************
    logic        por_q;
    logic        por_d;
    logic        rst_pulse_q;
    logic        rst_pulse_d;
    logic        restart_q;
    logic        restart_d;

    always_comb begin
        por_d       = 1'b0;
        rst_pulse_d = 1'b0;
        // Power-up start rides on the first cycle out of reset
        restart_d   = por_q;
        if (ctrl_wr && mgmt_req.wdata[BIT_RESTART]) begin
            restart_d = 1'b1;
        end
        if (ctrl_wr && mgmt_req.wdata[BIT_RESET]) begin
            rst_pulse_d = 1'b1;
            restart_d   = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            por_q       <= 1'b1;
            rst_pulse_q <= 1'b0;
            restart_q   <= 1'b0;
        end else begin
            por_q       <= por_d;
            rst_pulse_q <= rst_pulse_d;
            restart_q   <= restart_d;
        end
    end

    // ***********************************************
    // Read path
    // ***********************************************
    logic [15:0] status_w;
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    logic        rvalid_d;
    logic        rvalid_q;

    always_comb begin
        status_w = 16'h0000;
        // Hard-wired, never taken from control
        status_w[STATUS_ABIL_LSB +: 5] = STATUS_ABILITY;
        status_w[5] = autoneg_complete;
        status_w[3] = ctrl_q[BIT_ANEG_EN];
        status_w[2] = link_status;
        status_w[0] = 1'b1;
    end

    always_comb begin
        rvalid_d = mgmt_req.rd && (mgmt_req.phy_addr == PHY_MGMT_ADDRESS);
        rdata_d  = 16'h0000;
        if (rvalid_d) begin
            case (mgmt_req.reg_addr)
                REG_BASIC_CONTROL: rdata_d = ctrl_q & CTRL_WRITE_MASK;
                REG_BASIC_STATUS:  rdata_d = status_w;
                // Unsupported registers read as zero
                default:           rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ***********************************************
    // Datapath: loopback stages
    // ***********************************************
    // Two registered stages so loopback walks through internal logic
    pbc_mii_tx_s lb_s1_q;
    pbc_mii_tx_s lb_s1_d;
    pbc_mii_tx_s lb_s2_q;
    pbc_mii_tx_s lb_s2_d;

    always_comb begin
        lb_s1_d = mac_tx;
        lb_s2_d = lb_s1_q;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lb_s1_q <= '0;
            lb_s2_q <= '0;
        end else begin
            lb_s1_q <= lb_s1_d;
            lb_s2_q <= lb_s2_d;
        end
    end

    // ***********************************************
    // MII steering and collision test
    // ***********************************************
    pbc_mii_rx_s rx_q;
    pbc_mii_rx_s rx_d;
    pbc_mii_tx_s ltx_q;
    pbc_mii_tx_s ltx_d;
    logic        coltest;

    always_comb begin
        // Duplex intentionally not in this term
        coltest = ctrl_q[BIT_COLTEST] && !coding_sublayer_bypass;
        if (ctrl_q[BIT_LOOPBACK]) begin
            rx_d.rxd   = lb_s2_q.txd;
            rx_d.rx_dv = lb_s2_q.tx_en;
            rx_d.col   = coltest && mac_tx.tx_en;
            ltx_d      = '0;
        end else begin
            rx_d.rxd   = line_rx.rxd;
            rx_d.rx_dv = line_rx.rx_dv;
            rx_d.col   = coltest ? mac_tx.tx_en : line_rx.col;
            ltx_d      = ctrl_q[BIT_LOW_POWER_REQUEST] ? '0 : mac_tx;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_q    <= '0;
            ltx_q   <= '0;
        end else begin
            rx_q    <= rx_d;
            ltx_q   <= ltx_d;
        end
    end

    // ***********************************************
    // Outputs
    // ***********************************************
    always_comb begin
        mgmt_rdata          = rdata_q;
        mgmt_rvalid         = rvalid_q;
        mac_rx              = rx_q;
        line_tx             = ltx_q;
        core_reset          = rst_pulse_q;
        // Autoneg result owns mode when enabled; core ignores these then
        speed_100           = ctrl_q[BIT_SPEED];
        full_duplex         = ctrl_q[BIT_DUPLEX];
        autoneg_enable      = ctrl_q[BIT_ANEG_EN];
        autoneg_restart     = restart_q;
        low_power_request   = ctrl_q[BIT_LOW_POWER_REQUEST];
        digital_loopback_en = ctrl_q[BIT_LOOPBACK];
    end
endmodule
`default_nettype wire

// File: include/pbc_pkg.sv
`default_nettype none
package pbc_pkg;
    // ***********************************************
    // Management addressing
    // ***********************************************
    localparam logic [4:0] PHY_MGMT_ADDRESS      = 5'h01;
    localparam logic [4:0] REG_BASIC_CONTROL     = 5'h00;
    localparam logic [4:0] REG_BASIC_STATUS      = 5'h01;
    // ***********************************************
    // Control field positions
    // ***********************************************
    localparam int BIT_RESET    = 15;
    localparam int BIT_LOOPBACK = 14;
    localparam int BIT_SPEED    = 13;
    localparam int BIT_ANEG_EN  = 12;
    localparam int BIT_LOW_POWER_REQUEST    = 11;
    localparam int BIT_RESTART  = 9;
    localparam int BIT_DUPLEX   = 8;
    localparam int BIT_COLTEST  = 7;
    localparam logic [15:0] CTRL_RESET_VAL  = 16'h3100;
    localparam logic [15:0] CTRL_WRITE_MASK = 16'hF980;
    // Fixed abilities, bits 15..11
    localparam logic [4:0]  STATUS_ABILITY  = 5'h0F;
    localparam int          STATUS_ABIL_LSB = 11;
    // ***********************************************
    // Carriers
    // ***********************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  phy_addr;
        logic [4:0]  reg_addr;
        logic [15:0] wdata;
    } pbc_mgmt_req_s;
    typedef struct packed {
        logic [3:0] txd;
        logic       tx_en;
    } pbc_mii_tx_s;
    typedef struct packed {
        logic [3:0] rxd;
        logic       rx_dv;
        logic       col;
    } pbc_mii_rx_s;
endpackage
`default_nettype wire

// File: verification/pbc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pbc_checker
    import pbc_pkg::*;
(
    // Clock, management
    input wire logic          clk,
    input wire logic          reset,
    input wire pbc_mgmt_req_s mgmt_req,
    input wire logic [15:0]   mgmt_rdata,
    input wire logic          mgmt_rvalid,
    // Core controls
    input wire logic          core_reset,
    input wire logic          speed_100,
    input wire logic          full_duplex,
    input wire logic          autoneg_enable,
    input wire logic          autoneg_restart
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_cwr;
        mgmt_req.wr && mgmt_req.phy_addr == PHY_MGMT_ADDRESS
            && mgmt_req.reg_addr == REG_BASIC_CONTROL;
    endsequence
    rd_answer_a: assert property (mgmt_req.rd && mgmt_req.phy_addr == 5'h01
        |=> mgmt_rvalid) else $error("read unanswered");
    addr_refuse_a: assert property (mgmt_req.phy_addr != 5'h01
        |=> !mgmt_rvalid) else $error("foreign address answered");
    rsvd_zero_a: assert property (mgmt_rvalid && $past(mgmt_req.reg_addr) == 5'h00
        |-> (mgmt_rdata & ~CTRL_WRITE_MASK) == 16'h0000) else $error("reserved set");
    ability_fixed_a: assert property (mgmt_rvalid && $past(mgmt_req.reg_addr) == 5'h01
        |-> mgmt_rdata[15:11] == STATUS_ABILITY) else $error("ability moved");
    sw_reset_a: assert property (s_cwr ##0 mgmt_req.wdata[BIT_RESET]
        |=> core_reset && speed_100 && full_duplex && autoneg_enable ##1 !core_reset)
        else $error("soft reset wrong");
    restart_a: assert property (s_cwr ##0 mgmt_req.wdata[BIT_RESTART]
        |=> autoneg_restart ##1 !autoneg_restart) else $error("restart pulse wrong");
    mode_locked_a: assert property (s_cwr ##0 autoneg_enable && !mgmt_req.wdata[15]
        |=> $stable(speed_100) && $stable(full_duplex)) else $error("mode not locked");
    manual_cfg_a: assert property (s_cwr ##0 !autoneg_enable && !mgmt_req.wdata[15]
        |=> speed_100 == $past(mgmt_req.wdata[BIT_SPEED])
        && full_duplex == $past(mgmt_req.wdata[BIT_DUPLEX])) else $error("manual mode");
endmodule
bind pbc_basic_control pbc_checker u_chk (.clk, .reset, .mgmt_req, .mgmt_rdata,
    .mgmt_rvalid, .core_reset, .speed_100, .full_duplex, .autoneg_enable, .autoneg_restart);
`default_nettype wire

// File: verification/pbc_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module pbc_mac_model
    import pbc_pkg::*;
(
    // Management
    input  wire logic          clk,
    input  wire logic          mgmt_rvalid,
    input  wire logic [15:0]   mgmt_rdata,
    output var  pbc_mgmt_req_s mgmt_req
);
    initial mgmt_req = '0;
    // One-cycle pulse; the idle gap keeps two requests from meeting in one step
    task automatic access(input logic w, input logic [4:0] pa, ra,
        input logic [15:0] wd, output logic [15:0] q, output logic ok);
        @(negedge clk);
        mgmt_req = '{w, !w, pa, ra, wd};
        @(negedge clk);
        mgmt_req = '0;
        ok = mgmt_rvalid;
        q = mgmt_rdata;
    endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import pbc_pkg::*;
;
    logic clk, reset, mgmt_rvalid, coding_sublayer_bypass, link_status, autoneg_complete;
    logic core_reset, speed_100, full_duplex, autoneg_enable, autoneg_restart;
    logic low_power_request, digital_loopback_en, ok;
    logic [15:0] mgmt_rdata, v;
    pbc_mgmt_req_s mgmt_req;
    pbc_mii_tx_s mac_tx, line_tx;
    pbc_mii_rx_s mac_rx, line_rx;
    int fail_count, num_checks;
    pbc_basic_control dut (.clk, .reset, .mgmt_req, .mgmt_rdata, .mgmt_rvalid, .mac_tx,
        .mac_rx, .line_rx, .line_tx, .coding_sublayer_bypass, .link_status,
        .autoneg_complete, .core_reset, .speed_100, .full_duplex, .autoneg_enable,
        .autoneg_restart, .low_power_request, .digital_loopback_en);
    pbc_mac_model mac (.clk, .mgmt_rvalid, .mgmt_rdata, .mgmt_req);
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    task chk(input string n, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task rd(input logic [4:0] ra, input logic [15:0] e);
        mac.access(0, PHY_MGMT_ADDRESS, ra, 0, v, ok);
        chk("rvalid", 1, ok);
        chk("rdata", e, ra == 0 ? v : {v[15:11], 11'h000});
    endtask
    task wr(input logic [15:0] d);
        mac.access(1, PHY_MGMT_ADDRESS, REG_BASIC_CONTROL, d, v, ok);
    endtask
    task results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task t_modes;
        wr(16'h0000);
        rd(0, 16'h2100);
        chk("mode", 3'b110, {speed_100, full_duplex, autoneg_enable});
        wr(16'h1000);
        wr(16'h2100);
        rd(0, 16'h0000);
        rd(1, 16'h7800);
        $display("test modes done");
    endtask
    task t_refuse;
        mac.access(0, 5'h02, 0, 0, v, ok);
        chk("foreign", 0, ok);
        mac.access(1, 5'h02, 0, 16'h4000, v, ok);
        wr(16'h4CFF);
        rd(0, 16'h4880);
        chk("lp", 2'b11, {low_power_request, digital_loopback_en});
        $display("test refuse done");
    endtask
    task t_loop;
        mac_tx = '{4'hA, 1'b1};
        @(negedge clk);
        chk("col", 1, mac_rx.col);
        chk("line", 0, line_tx.tx_en);
        repeat (4) if (!mac_rx.rx_dv) @(negedge clk);
        chk("loop", 5'h15, {mac_rx.rxd, mac_rx.rx_dv});
        mac_tx = '0;
        coding_sublayer_bypass = 1;
        @(negedge clk);
        mac_tx = '{4'hA, 1'b1};
        @(negedge clk);
        chk("col", 0, mac_rx.col);
        $display("test loop done");
    endtask
    task t_line;
        coding_sublayer_bypass = 0;
        wr(16'h0180);
        @(negedge clk);
        chk("col_fd", 1, mac_rx.col);
        chk("line_tx", 5'h15, line_tx);
        wr(16'h0800);
        @(negedge clk);
        chk("line_pd", 0, line_tx);
        rd(0, 16'h0800);
        mac_tx = '0;
        $display("test line done");
    endtask
    task t_reset;
        wr(16'h8000);
        rd(0, 16'h3100);
        wr(16'h3200);
        rd(0, 16'h3100);
        $display("test reset done");
    endtask
    initial begin
        reset = 1;
        {coding_sublayer_bypass, link_status, autoneg_complete} = 3'b011;
        mac_tx = '0;
        line_rx = '{4'h5, 1'b1, 1'b1};
        fail_count = 0;
        num_checks = 0;
        repeat (6) @(negedge clk);
        reset = 0;
        ok = 0;
        repeat (4) begin
            @(negedge clk);
            ok |= autoneg_restart;
        end
        chk("start", 1, ok);
        rd(0, 16'h3100);
        t_modes;
        t_refuse;
        t_loop;
        t_line;
        t_reset;
        results;
    end
    initial begin
        #100us;
        fail_count++;
        results;
    end
endmodule
`default_nettype wire
